// *** dior_ctrl_model.sv ***
// controller side of the command link, one command per cmd_clk period
// assumes the caller spaces commands; cmd_clk stands low between frames
module dior_ctrl_model (
  output logic       cmd_clk,
  output logic       cmd_valid,
  output logic       cmd_read,
  output logic [5:0] cmd_addr,
  output logic [7:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cmd_clk, cmd_valid, cmd_read, cmd_addr, cmd_wdata} = 17'h00000;
  end
  task automatic issue(input logic rd, input logic [5:0] a, input logic [7:0] d);
    {cmd_valid, cmd_read, cmd_addr, cmd_wdata} = {1'b1, rd, a, d};
    #400 cmd_clk = 1'b1;
    #400 cmd_clk = 1'b0;
    // hold time over: inverted pins so stale values cannot pass
    {cmd_valid, cmd_read, cmd_addr, cmd_wdata} = {1'b0, ~rd, ~a, ~d};
  endtask
endmodule // dior_ctrl_model

// *** dior_defines.vh ***
// constants for the io-config and refresh/thermal mode register bank
// assumes inclusion by bare name from every design file of the bank
`ifndef DIOR_DEFINES_VH
`define DIOR_DEFINES_VH

// mode register addresses
`define DIOR_MA_W           6
`define DIOR_MA_IO_CFG      6'h03
`define DIOR_MA_RFT         6'h04

// io config field positions and reset value
`define DIOR_IO_PULLUP_CAL_POINT      0
`define DIOR_IO_WRITE_POSTAMBLE_LEN      1
`define DIOR_IO_LOCK        2
`define DIOR_IO_PULLDOWN_DRIVE_STRENGTH_LO     3
`define DIOR_IO_PULLDOWN_DRIVE_STRENGTH_HI     5
`define DIOR_IO_READ_INVERSION_ENABLE      6
`define DIOR_IO_WRITE_INVERSION_ENABLE      7
`define DIOR_IO_RST         8'h31

// refresh/thermal field positions
`define DIOR_RFT_RATE_LO    0
`define DIOR_RFT_RATE_HI    2
`define DIOR_RFT_SRA        3
`define DIOR_RFT_REPAIR_ENTRY       4
`define DIOR_RFT_TOFS_LO    5
`define DIOR_RFT_TOFS_HI    6
`define DIOR_RFT_TUF        7

// codes and reset values
`define DIOR_RATE_RST       3'h3
`define DIOR_RATE_DERATE    3'h6
`define DIOR_TOFS_RST       2'h0
`define DIOR_TOFS_RSVD      2'h3
`define DIOR_RD_UNMAPPED    8'h00

// synchroniser bundle: link clock, valid, read, address, data
`define DIOR_SYNC_W         17

`endif

// *** dior_regs.v ***
// io-config and refresh/thermal mode registers of one dram channel
// assumes cmd_* pins held stable from before the rising to the falling edge of cmd_clk,
// and set-point selects, temperature code and density strap from clk_sys logic
`include "dior_defines.vh"

module dior_regs (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       cmd_clk,
  input  wire       cmd_valid,
  input  wire       cmd_read,
  input  wire [5:0] cmd_addr,
  input  wire [7:0] cmd_wdata,
  input  wire       write_set_point_select,
  input  wire       operating_set_point_select,
  input  wire [2:0] temp_rate_code,
  input  wire       temp_sensed,
  input  wire       density_12gb_up,
  output wire [7:0] mrr_data,
  output wire       mrr_valid,
  output wire       mrw_refused,
  output wire       pullup_cal_point,
  output wire       write_postamble_len,
  output wire [2:0] pulldown_drive_strength,
  output wire       read_inversion_enable,
  output wire       write_inversion_enable,
  output wire       repair_protect_lock,
  output wire       repair_entry,
  output wire       self_refresh_abort_enable,
  output wire [1:0] thermal_offset,
  output wire [2:0] refresh_rate,
  output wire       temperature_update_flag
);

  localparam ST_STRAP = 2'b01;
  localparam ST_RUN   = 2'b10;

  wire [`DIOR_SYNC_W-1:0] sync_bus;
  wire                    clk_s;
  wire                    valid_s;
  wire                    read_s;
  wire [5:0]              addr_s;
  wire [7:0]              wdata_s;

  reg        clk_d_r;
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg        dens_r;
  reg  [7:0] cfg_mem_r [0:1];
  reg  [7:0] op_cfg_r;
  reg        lock_r;
  reg        repair_entry_r;
  reg        sra_r;
  reg        sra_eff_r;
  reg  [1:0] tofs_r;
  reg  [2:0] rate_r;
  reg        tuf_r;
  reg        tuf_nxt;
  reg  [7:0] rd_data_r;
  reg  [7:0] rd_data_nxt;
  reg        rd_valid_r;
  reg        refused_r;

  // link clock and command pins cross together, so both arrive equally late
  dior_sync #(
    .WIDTH (`DIOR_SYNC_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in ({cmd_clk, cmd_valid, cmd_read, cmd_addr, cmd_wdata}),
    .sync_out (sync_bus)
  );

  assign clk_s   = sync_bus[16];
  assign valid_s = sync_bus[15];
  assign read_s  = sync_bus[14];
  assign addr_s  = sync_bus[13:8];
  assign wdata_s = sync_bus[7:0];

  wire take    = clk_s & ~clk_d_r & valid_s & state_r[1];
  wire wr      = take & ~read_s;
  wire rd      = take & read_s;
  wire hit_io  = (addr_s == `DIOR_MA_IO_CFG);
  wire hit_rft = (addr_s == `DIOR_MA_RFT);
  wire wr_io   = wr & hit_io;
  wire refuse  = wr & hit_rft & lock_r & wdata_s[`DIOR_RFT_REPAIR_ENTRY];
  wire wr_rft  = wr & hit_rft & ~refuse;
  wire rd_rft  = rd & hit_rft;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= clk_s;
    end
  end

  // strap is caught one cycle after reset release, never under reset
  always @* begin
    case (state_r)
      ST_STRAP: state_nxt = ST_RUN;
      ST_RUN:   state_nxt = ST_RUN;
      default:  state_nxt = ST_STRAP;
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_STRAP;
      dens_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r[0]) begin
        dens_r <= density_12gb_up;
      end
    end
  end

  // per set-point copies; lock bit held apart since it has no copies
  genvar sp;
  generate
    for (sp = 0; sp < 2; sp = sp + 1) begin : g_sp
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cfg_mem_r[sp] <= `DIOR_IO_RST;
        end else if (wr_io && (write_set_point_select == sp)) begin
          cfg_mem_r[sp] <= wdata_s;
        end
      end
    end
  endgenerate

  // operating copy refreshed every cycle; inactive copy reaches pins only through mrr_data on reads
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      op_cfg_r <= `DIOR_IO_RST;
    end else begin
      op_cfg_r <= cfg_mem_r[operating_set_point_select];
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= 1'b0;
    end else if (wr_io && wdata_s[`DIOR_IO_LOCK]) begin
      lock_r <= 1'b1;
    end
  end

  // reserved offset code leaves the previous offset in place
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      repair_entry_r <= 1'b0;
      sra_r  <= 1'b0;
      tofs_r <= `DIOR_TOFS_RST;
    end else if (wr_rft) begin
      repair_entry_r <= wdata_s[`DIOR_RFT_REPAIR_ENTRY];
      sra_r  <= wdata_s[`DIOR_RFT_SRA];
      if (wdata_s[`DIOR_RFT_TOFS_HI:`DIOR_RFT_TOFS_LO] != `DIOR_TOFS_RSVD) begin
        tofs_r <= wdata_s[`DIOR_RFT_TOFS_HI:`DIOR_RFT_TOFS_LO];
      end
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sra_eff_r <= 1'b0;
    end else begin
      sra_eff_r <= sra_r & dens_r;
    end
  end

  // sensor supplies the full code, including derating and the 85 degree bit
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rate_r <= `DIOR_RATE_RST;
    end else if (temp_sensed) begin
      rate_r <= temp_rate_code;
    end
  end

  // a change seen in the same cycle as the clearing read still sets
  always @* begin
    tuf_nxt = tuf_r;
    if (rd_rft) begin
      tuf_nxt = 1'b0;
    end
    if (temp_sensed && (temp_rate_code != rate_r)) begin
      tuf_nxt = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tuf_r <= 1'b0;
    end else begin
      tuf_r <= tuf_nxt;
    end
  end

  always @* begin
    rd_data_nxt = `DIOR_RD_UNMAPPED;
    if (hit_io) begin
      rd_data_nxt = cfg_mem_r[write_set_point_select];
      rd_data_nxt[`DIOR_IO_LOCK] = lock_r;
    end else if (hit_rft) begin
      rd_data_nxt = {tuf_r, tofs_r, repair_entry_r, sra_r, rate_r};
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r  <= `DIOR_RD_UNMAPPED;
      rd_valid_r <= 1'b0;
      refused_r  <= 1'b0;
    end else begin
      rd_valid_r <= rd;
      refused_r  <= refuse;
      if (rd) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  assign mrr_data                  = rd_data_r;
  assign mrr_valid                 = rd_valid_r;
  assign mrw_refused               = refused_r;
  assign pullup_cal_point          = op_cfg_r[`DIOR_IO_PULLUP_CAL_POINT];
  assign write_postamble_len       = op_cfg_r[`DIOR_IO_WRITE_POSTAMBLE_LEN];
  assign pulldown_drive_strength   = op_cfg_r[`DIOR_IO_PULLDOWN_DRIVE_STRENGTH_HI:`DIOR_IO_PULLDOWN_DRIVE_STRENGTH_LO];
  assign read_inversion_enable     = op_cfg_r[`DIOR_IO_READ_INVERSION_ENABLE];
  assign write_inversion_enable    = op_cfg_r[`DIOR_IO_WRITE_INVERSION_ENABLE];
  assign repair_protect_lock       = lock_r;
  assign repair_entry              = repair_entry_r;
  assign self_refresh_abort_enable = sra_eff_r;
  assign thermal_offset            = tofs_r;
  assign refresh_rate              = rate_r;
  assign temperature_update_flag   = tuf_r;

endmodule // dior_regs

// *** dior_regs_props.sv ***
// assertions on the ports of the mode register bank
// assumes one clk_sys domain; bound onto every dior_regs instance
module dior_regs_props (
  input logic       clk_sys,
  input logic       rst_b,
  input logic [2:0] temp_rate_code,
  input logic       temp_sensed,
  input logic       density_12gb_up,
  input logic       mrr_valid,
  input logic       mrw_refused,
  input logic       repair_protect_lock,
  input logic       repair_entry,
  input logic       self_refresh_abort_enable,
  input logic [1:0] thermal_offset,
  input logic [2:0] refresh_rate,
  input logic       temperature_update_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_rd_pulse;
    mrr_valid ##1 !mrr_valid;
  endsequence
  sequence s_rate_moved;
    $past(temp_sensed) ##0 refresh_rate == $past(temp_rate_code);
  endsequence
  chk_read_pulse: assert property (mrr_valid |-> s_rd_pulse)
    else $error("read valid wider than one cycle");
  chk_refuse_pulse: assert property (mrw_refused |=> !mrw_refused)
    else $error("refused pulse wider than one cycle");
  chk_refuse_locked: assert property (mrw_refused |-> repair_protect_lock)
    else $error("write refused without lock");
  chk_lock_sticky: assert property (repair_protect_lock |=> repair_protect_lock)
    else $error("repair lock dropped");
  chk_entry_blocked: assert property ($rose(repair_entry) |-> !$past(repair_protect_lock))
    else $error("repair entry while locked");
  chk_rate_source: assert property ($changed(refresh_rate) |-> s_rate_moved)
    else $error("rate moved without sensor code");
  chk_flag_sets: assert property ($changed(refresh_rate) |-> temperature_update_flag)
    else $error("rate change without update flag");
  chk_offset_legal: assert property (thermal_offset != 2'h3)
    else $error("reserved offset stored");
  chk_sra_strap: assert property (self_refresh_abort_enable |-> density_12gb_up)
    else $error("abort enabled on small density");
endmodule // dior_regs_props

bind dior_regs dior_regs_props chk (.clk_sys, .rst_b, .temp_rate_code, .temp_sensed,
  .density_12gb_up, .mrr_valid, .mrw_refused, .repair_protect_lock, .repair_entry,
  .self_refresh_abort_enable, .thermal_offset, .refresh_rate, .temperature_update_flag);

// *** dior_regs_tb.sv ***
// self-checking bench for the mode register bank
// assumes dior_ctrl_model drives the link and the checker is bound
module dior_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, write_set_point_select, operating_set_point_select, temp_sensed;
  logic [2:0] temp_rate_code;
  logic [7:0] last_rd;
  wire cmd_clk, cmd_valid, cmd_read, mrr_valid, mrw_refused, pullup_cal_point;
  wire write_postamble_len, read_inversion_enable, write_inversion_enable;
  wire repair_protect_lock, repair_entry, self_refresh_abort_enable, temperature_update_flag;
  wire [5:0] cmd_addr;
  wire [7:0] cmd_wdata, mrr_data;
  wire [2:0] pulldown_drive_strength, refresh_rate;
  wire [1:0] thermal_offset;
  // strap is driven so the small-density case can be exercised after a second reset
  logic density_12gb_up = 1'b1;
  wire [7:0] io_out = {write_inversion_enable, read_inversion_enable, pulldown_drive_strength,
    repair_protect_lock, write_postamble_len, pullup_cal_point};
  wire [7:0] rft_out = {temperature_update_flag, thermal_offset, repair_entry,
    self_refresh_abort_enable, refresh_rate};
  integer num_errors = 0, compares = 0, n_rd = 0, n_ref = 0, cyc = 0;

  dior_ctrl_model ctl (.cmd_clk, .cmd_valid, .cmd_read, .cmd_addr, .cmd_wdata);
  dior_regs uut (.clk_sys, .rst_b, .cmd_clk, .cmd_valid, .cmd_read, .cmd_addr, .cmd_wdata,
    .write_set_point_select, .operating_set_point_select, .temp_rate_code, .temp_sensed,
    .density_12gb_up, .mrr_data, .mrr_valid, .mrw_refused, .pullup_cal_point,
    .write_postamble_len, .pulldown_drive_strength, .read_inversion_enable,
    .write_inversion_enable, .repair_protect_lock, .repair_entry, .self_refresh_abort_enable,
    .thermal_offset, .refresh_rate, .temperature_update_flag);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // pulses are one cycle wide, so they are caught here rather than polled
  always @(posedge clk_sys) begin
    cyc++;
    if (mrr_valid === 1'b1) begin
      last_rd = mrr_data;
      n_rd++;
    end
    if (mrw_refused === 1'b1) n_ref++;
    if (cyc == 5000) begin
      num_errors++;
      test_done;
    end
  end

  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    ctl.issue(1'b0, a, d);
    tick(4);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    integer n, i;
    n = n_rd;
    ctl.issue(1'b1, a, 8'h00);
    for (i = 0; i < 12 && n_rd == n; i++) tick(1);
    // a missing read strobe must not pass on stale data
    chk(8'(n_rd - n), 8'h01);
    chk(last_rd, exp);
  endtask
  task automatic t_temp;
    logic [2:0] prev, k;
    integer c;
    prev = 3'h3;
    // each code sensed twice, so the second read sees no change
    for (c = 0; c < 16; c++) begin
      k = c[3:1];
      temp_rate_code = k;
      temp_sensed = 1'b1;
      tick(1);
      temp_sensed = 1'b0;
      tick(2);
      chk({5'h00, refresh_rate}, {5'h00, k});
      rd(6'h04, {k != prev, 4'h0, k});
      chk({7'h00, temperature_update_flag}, 8'h00);
      prev = k;
    end
  endtask
  task automatic t_io;
    wr(6'h03, 8'hca);
    chk(io_out, 8'hca);
    rd(6'h03, 8'hca);
  endtask
  task automatic t_fsp;
    write_set_point_select = 1'b1;
    wr(6'h03, 8'h30);
    chk(io_out, 8'hca);
    rd(6'h03, 8'h30);
    operating_set_point_select = 1'b1;
    tick(3);
    chk(io_out, 8'h30);
    {write_set_point_select, operating_set_point_select} = 2'b00;
    tick(3);
    chk(io_out, 8'hca);
  endtask
  task automatic t_rft;
    wr(6'h04, 8'hff);
    rd(6'h04, 8'h1f);
    chk({7'h00, self_refresh_abort_enable}, 8'h01);
    wr(6'h04, 8'h40);
    rd(6'h04, 8'h47);
    wr(6'h04, 8'h20);
    rd(6'h04, 8'h27);
    wr(6'h05, 8'hff);
    rd(6'h05, 8'h00);
  endtask
  task automatic t_lock;
    integer n;
    wr(6'h03, 8'hce);
    chk(io_out, 8'hce);
    wr(6'h03, 8'hca);
    chk(io_out, 8'hce);
    rd(6'h03, 8'hce);
    n = n_ref;
    wr(6'h04, 8'h18);
    chk(8'(n_ref - n), 8'h01);
    rd(6'h04, 8'h27);
    chk({7'h00, repair_entry}, 8'h00);
    wr(6'h04, 8'h08);
    rd(6'h04, 8'h0f);
  endtask
  task automatic t_strap;
    density_12gb_up = 1'b0;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(12);
    chk(io_out, 8'h31);
    chk(rft_out, 8'h03);
    wr(6'h04, 8'h08);
    rd(6'h04, 8'h0b);
    chk({7'h00, self_refresh_abort_enable}, 8'h00);
  endtask

  initial begin
    {rst_b, write_set_point_select, operating_set_point_select, temp_sensed} = 4'h0;
    temp_rate_code = 3'h3;
    tick(2);
    rst_b = 1'b1;
    tick(12);
    chk(io_out, 8'h31);
    chk(rft_out, 8'h03);
    t_temp;
    t_io;
    t_fsp;
    t_rft;
    t_lock;
    t_strap;
    test_done;
  end
endmodule // dior_regs_tb

// *** dior_sync.v ***
// two-flop synchroniser, one stage pair per bit
// assumes asynchronous inputs; outputs are safe to use in the clk_sys domain
`include "dior_defines.vh"

module dior_sync #(
  parameter WIDTH = `DIOR_SYNC_W
) (
  input  wire             clk_sys,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          stage1_r[i] <= 1'b0;
          stage2_r[i] <= 1'b0;
        end else begin
          stage1_r[i] <= async_in[i];
          stage2_r[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2_r;

endmodule // dior_sync
